// File: smc_cfg.svh
// Constants for the stepper motion configuration block
`ifndef SMC_CFG_SVH
`define SMC_CFG_SVH
// ****************************************************************
// Parameter indices on the configuration port
// ****************************************************************
`define SMC_IDX_ACC_CUR   4'h1
`define SMC_IDX_DEC_CUR   4'h2
`define SMC_IDX_HOLD_CUR  4'h3
`define SMC_IDX_RUN_CUR   4'h4
`define SMC_IDX_STEP_MODE 4'h5
`define SMC_IDX_ACC       4'h6
`define SMC_IDX_DEC       4'h7
`define SMC_IDX_MAX_SPD   4'h8
`define SMC_IDX_MIN_SPD   4'h9
`define SMC_IDX_FULL_SPD  4'hA
// ****************************************************************
// Ranges, values times one hundred
// ****************************************************************
`define SMC_ACC_MIN       32'h0000_05AF
`define SMC_ACC_MAX       32'h005A_ED58
`define SMC_ACC_RES       32'h0000_05AF
`define SMC_MAX_MIN       32'h0000_05F5
`define SMC_MAX_MAX       32'h0017_D1A8
`define SMC_SPD_RES       32'h0000_05F5
`define SMC_MIN_MAX       32'h0001_7D5E
`define SMC_FULL_MIN      32'h0000_02FB
`define SMC_FULL_MAX      32'h0017_D784
`define SMC_BYTE_MAX      32'h0000_00FF
// ****************************************************************
// Current scale: peak mA per LSB is 7.8 A / 100
// ****************************************************************
`define SMC_CUR_MA_LSB    15'h004E
`define SMC_RES_MAX       4'h4
`define SMC_ENC_SEL       4'h1
// ****************************************************************
// Reset values
// ****************************************************************
`define SMC_RST_CUR       32'h0000_0020
`define SMC_RST_STEP_MODE 32'h0000_0040
`define SMC_RST_ACC       32'h0000_B5E0
`define SMC_RST_MAX_SPD   32'h0001_86A0
`define SMC_RST_MIN_SPD   32'h0000_0000
`define SMC_RST_FULL_SPD  32'h0007_A120
// ****************************************************************
// Timing
// ****************************************************************
`define SMC_CLK_NS        5
`define SMC_RAMP_TICK_NS  1000000
`define SMC_RAMP_CYC      (`SMC_RAMP_TICK_NS / `SMC_CLK_NS)
`define SMC_US_TICK_NS    1000
`define SMC_US_CYC        (`SMC_US_TICK_NS / `SMC_CLK_NS)
`define SMC_RAMP_PER_S    32'd1000
`define SMC_STEP_THR      32'h05F5_E100
`endif

// File: smc_field_model.sv
// Field side model: input pins and motor step counter
`timescale 1ns/1ps
module smc_field_model (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        arst_n,
  // Requests from the bench
  input  wire logic [1:0]  diReq,
  input  wire logic [1:0]  stopReq,
  // Device side
  input  wire logic        stepPulse,
  output logic      [3:0]  fieldIn,
  output logic      [15:0] steps
);
  // ****************************************************************
  // Pins: two shared inputs low, two hard stops high
  // ****************************************************************
  assign fieldIn = {stopReq, diReq};
  // ****************************************************************
  // Motor: one step per pulse
  // ****************************************************************
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) steps <= 16'h0000;
    else if (stepPulse) steps <= steps + 16'h0001;
  end
endmodule : smc_field_model

// File: smc_in_if.sv
// Carrier between input conditioning and the motion core
`timescale 1ns/1ps
interface smc_in_if;
  logic [3:0]  level;
  logic [15:0] encCount;
  logic        encMode;
  modport prod (output level, output encCount, input encMode);
  modport cons (input level, input encCount, output encMode);
endinterface : smc_in_if

// File: smc_inputs.sv
// Field input synchronisers and AB encoder counter
`timescale 1ns/1ps
module smc_inputs
  import smc_pkg::*;
(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       arst_n,
  // Field pins
  input  wire logic [3:0] fieldIn,
  // Core side
  smc_in_if.prod          inBus
);
  logic [3:0]  syncA;
  logic [3:0]  syncB;
  logic [1:0]  abOld;
  logic [15:0] count;
  logic [15:0] next_count;
  logic        step;
  logic        fwd;

  // ****************************************************************
  // Quadrature decode
  // ****************************************************************
  always_comb begin
    step       = (syncB[0] != abOld[0]) ^ (syncB[1] != abOld[1]);
    fwd        = syncB[0] ^ abOld[1];
    next_count = count;
    if (inBus.encMode && step) begin // [R6]
      next_count = fwd ? count + 16'h0001 : count - 16'h0001;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      syncA <= 4'h0;
      syncB <= 4'h0;
      abOld <= 2'h0;
      count <= 16'h0000;
    end else begin
      syncA <= fieldIn; // [R18]
      syncB <= syncA;
      abOld <= syncB[1:0];
      count <= next_count;
    end
  end

  assign inBus.level    = syncB;
  assign inBus.encCount = count;
endmodule : smc_inputs

// File: smc_pkg.sv
// Types for the stepper motion configuration block
package smc_pkg;
  typedef enum logic [3:0] {
    SMC_IDLE  = 4'h1,
    SMC_ACCEL = 4'h2,
    SMC_CONST = 4'h4,
    SMC_DECEL = 4'h8
  } smc_state_t;
  typedef enum logic [1:0] {
    SMC_CMD_OK = 2'h0, SMC_CMD_ERR = 2'h1, SMC_CMD_BUSY = 2'h2
  } smc_cmd_stat_t;
  typedef enum logic [1:0] {
    SMC_MOT_STOP = 2'h0, SMC_MOT_ACC = 2'h1,
    SMC_MOT_DEC  = 2'h2, SMC_MOT_CONST = 2'h3
  } smc_mot_stat_t;
  typedef enum logic [2:0] {
    SMC_OP_NOP = 3'h0, SMC_OP_HIZ = 3'h1, SMC_OP_STOP = 3'h2,
    SMC_OP_RUN = 3'h3, SMC_OP_MOVE = 3'h4
  } smc_op_t;
endpackage : smc_pkg

// File: smc_top.sv
// Stepper motion configuration and command core
// Function
// R1: Current bytes scale to peak amperes as 7.8 times value over 100.
// R2: Configuration writes are taken only while outputs are high impedance.
// R3: Current write while driving forces the outputs into high impedance.
// R4: Master must command high impedance before changing any parameter.
// R5: Step-mode upper nibble selects full, half, 1/4, 1/8, 1/16 stepping.
// R6: Step-mode lower nibble selects digital inputs or AB encoder.
// R7: Rates span 14.55 to 59590 steps/s2 in 14.55 steps.
// R8: Acceleration at 59590 means infinite acceleration, no ramp.
// R9: Infinite acceleration ignores the deceleration rate.
// R10: Maximum speed spans 15.25 to 15610 steps/s in 15.25 steps.
// R11: Minimum speed spans 0 to 976.3 steps/s, resolution 0.238; the code clamps but keeps any value in 0.01 steps.
// R12: Zero minimum speed enables low speed optimisation.
// R13: Above full step speed threshold the drive switches to full step.
// R14: Speeds and rates travel as unsigned integers, value times one hundred.
// R15: After power-up report ready, motor neutral and unheld.
// R16: Instant commands execute, then last status stays and position holds.
// R17: Instant command mode and position table mode exist; the code has no table, and in posTableMode every command but NOP returns error.
// R18: Four sink inputs: two digital or encoder, two hard stop.
// R19: An active hard-stop input stops the motor.
// R20: Command status 0 ok,1 error,2 busy; motion 0 to 3.
// R21: Out of range speed or rate writes clamp to the nearest limit.
`timescale 1ns/1ps
`include "smc_cfg.svh"
module smc_top
  import smc_pkg::*;
#(
  parameter int unsigned RAMP_CYCLES = `SMC_RAMP_CYC
)
(
  // Clock and reset
  input  wire  logic        clock,
  input  wire  logic        arst_n,
  // Configuration port
  input  wire  logic        cfgWrEn,
  input  wire  logic [3:0]  cfgIndex,
  input  wire  logic [31:0] cfgData,
  // Command port
  input  wire  logic        cmdValid,
  input  wire  logic [2:0]  cmdCode,
  input  wire  logic        cmdFwd,
  input  wire  logic [23:0] cmdSteps,
  input  wire  logic        posTableMode,
  // Field inputs
  input  wire  logic [3:0]  fieldIn,
  // Status
  output logic              ready,
  output logic              hiZ,
  output logic              busy,
  output logic              dirFwd,
  output logic [1:0]        cmdStatus,
  output logic [1:0]        motStatus,
  output logic              cfgReject,
  // Drive
  output logic              stepPulse,
  output logic              fullStep,
  output logic [2:0]        stepRes,
  output logic [7:0]        phaseCur,
  output logic [14:0]       phaseCurMa,
  output logic              lowSpeedOpt,
  output logic              infiniteAcc,
  // Input image
  output logic              encMode,
  output logic [3:0]        diLevel,
  output logic [15:0]       encCount
);
  localparam int unsigned US_CYCLES = `SMC_US_CYC;

  smc_in_if inBus ();

  smc_inputs u_inputs (
    .clock   (clock),
    .arst_n  (arst_n),
    .fieldIn (fieldIn),
    .inBus   (inBus)
  );

  // ****************************************************************
  // Parameter store
  // ****************************************************************
  logic [31:0] prm      [1:10];
  logic [31:0] next_prm [1:10];
  logic        next_cfgReject;
  logic        forceHiz;
  logic        curIdx;
  logic        idxOk;

  function automatic logic [31:0] clampParam(input logic [3:0]  idx,
                                             input logic [31:0] v);
    logic [31:0] r;
    begin
      r = v;
      case (idx)
        `SMC_IDX_ACC, `SMC_IDX_DEC: begin
          r = (v < `SMC_ACC_MIN) ? `SMC_ACC_MIN : // [R7] [R21]
              (v > `SMC_ACC_MAX) ? `SMC_ACC_MAX : v;
          if (r != `SMC_ACC_MAX) r = r - (r % `SMC_ACC_RES); // [R7]
        end
        `SMC_IDX_MAX_SPD: begin
          r = (v < `SMC_MAX_MIN) ? `SMC_MAX_MIN : // [R10] [R21]
              (v > `SMC_MAX_MAX) ? `SMC_MAX_MAX : v;
          if (r != `SMC_MAX_MAX) r = r - (r % `SMC_SPD_RES); // [R10]
        end
        `SMC_IDX_MIN_SPD: begin
          r = (v > `SMC_MIN_MAX) ? `SMC_MIN_MAX : v; // [R11] [R21]
        end
        `SMC_IDX_FULL_SPD: begin
          r = (v < `SMC_FULL_MIN) ? `SMC_FULL_MIN : // [R13] [R21]
              (v > `SMC_FULL_MAX) ? `SMC_FULL_MAX : v;
        end
        default: begin
          r = (v > `SMC_BYTE_MAX) ? `SMC_BYTE_MAX : v;
        end
      endcase
      clampParam = r;
    end
  endfunction : clampParam

  always_comb begin
    next_prm       = prm;
    curIdx         = (cfgIndex >= `SMC_IDX_ACC_CUR) &&
                     (cfgIndex <= `SMC_IDX_RUN_CUR);
    idxOk          = (cfgIndex >= `SMC_IDX_ACC_CUR) &&
                     (cfgIndex <= `SMC_IDX_FULL_SPD);
    next_cfgReject = cfgWrEn && !hiZ; // [R2] [R4]
    forceHiz       = cfgWrEn && !hiZ && curIdx; // [R3]
    if (cfgWrEn && hiZ && idxOk) begin // [R2]
      next_prm[cfgIndex] = clampParam(cfgIndex, cfgData); // [R14]
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 1; i <= 4; i++) prm[i] <= `SMC_RST_CUR;
      prm[5]    <= `SMC_RST_STEP_MODE;
      prm[6]    <= `SMC_RST_ACC;
      prm[7]    <= `SMC_RST_ACC;
      prm[8]    <= `SMC_RST_MAX_SPD;
      prm[9]    <= `SMC_RST_MIN_SPD;
      prm[10]   <= `SMC_RST_FULL_SPD;
      cfgReject <= 1'b0;
    end else begin
      prm       <= next_prm;
      cfgReject <= next_cfgReject;
    end
  end

  // ****************************************************************
  // Motion engine
  // ****************************************************************
  smc_state_t  state;
  smc_state_t  next_state;
  logic [31:0] speed, next_speed, stepAcc, next_stepAcc;
  logic [23:0] remain, next_remain, accSteps, next_accSteps;
  logic [17:0] rampCnt, next_rampCnt;
  logic [7:0]  usCnt, next_usCnt;
  logic        moveMode, next_moveMode;
  logic        next_hiZ, next_busy, next_dirFwd, next_stepPulse;
  logic [1:0]  next_cmdStatus, next_motStatus;
  logic        next_fullStep, next_lowSpeedOpt, next_infiniteAcc;
  logic [2:0]  next_stepRes;
  logic [7:0]  next_phaseCur;
  logic        rampTick, usTick, hardStop, infAcc, startOk;
  logic [31:0] accDelta, decDelta, maxSpd, minSpd;

  always_comb begin
    next_state     = state;
    next_speed     = speed;
    next_stepAcc   = stepAcc;
    next_remain    = remain;
    next_accSteps  = accSteps;
    next_moveMode  = moveMode;
    next_hiZ       = hiZ;
    next_busy      = busy;
    next_dirFwd    = dirFwd;
    next_cmdStatus = cmdStatus;
    next_stepPulse = 1'b0;
    rampTick       = (rampCnt == 18'(RAMP_CYCLES - 1));
    usTick         = (usCnt == 8'(US_CYCLES - 1));
    next_rampCnt   = rampTick ? 18'h00000 : rampCnt + 18'h00001;
    next_usCnt     = usTick ? 8'h00 : usCnt + 8'h01;
    hardStop       = inBus.level[2] || inBus.level[3]; // [R18]
    infAcc         = (prm[6] == `SMC_ACC_MAX); // [R8]
    accDelta       = prm[6] / `SMC_RAMP_PER_S;
    decDelta       = prm[7] / `SMC_RAMP_PER_S;
    maxSpd         = prm[8];
    minSpd         = prm[9];
    startOk        = !posTableMode && !hardStop;
    // Ramp
    if (rampTick) begin
      case (state)
        SMC_ACCEL: begin
          if (infAcc || speed + accDelta >= maxSpd) begin // [R8]
            next_speed = maxSpd;
            next_state = SMC_CONST;
          end else begin
            next_speed = speed + accDelta;
          end
        end
        SMC_DECEL: begin
          if (infAcc || speed <= decDelta + minSpd) begin // [R9]
            next_speed     = 32'h0;
            next_state     = SMC_IDLE;
            next_busy      = 1'b0;
            next_cmdStatus = SMC_CMD_OK; // [R16]
          end else begin
            next_speed = speed - decDelta;
          end
        end
        default: begin
        end
      endcase
    end
    // Step generation
    if (usTick && state != SMC_IDLE) begin
      next_stepAcc = stepAcc + speed;
      if (next_stepAcc >= `SMC_STEP_THR) begin
        next_stepAcc   = next_stepAcc - `SMC_STEP_THR;
        next_stepPulse = 1'b1;
        next_remain    = remain - 24'h000001;
        if (state == SMC_ACCEL) next_accSteps = accSteps + 24'h000001;
        if (moveMode && remain == 24'h000001) begin
          next_state     = SMC_IDLE;
          next_speed     = 32'h0;
          next_busy      = 1'b0;
          next_cmdStatus = SMC_CMD_OK; // [R16]
        end
      end
    end
    if (moveMode && !infAcc && next_remain <= accSteps &&
        (state == SMC_ACCEL || state == SMC_CONST)) begin
      next_state = SMC_DECEL;
    end
    // Instant commands
    if (cmdValid && cmdCode != SMC_OP_NOP) begin
      if (posTableMode) begin
        next_cmdStatus = SMC_CMD_ERR; // [R17]
      end else begin
        case (cmdCode)
          SMC_OP_HIZ: begin
            next_state     = SMC_IDLE;
            next_speed     = 32'h0;
            next_hiZ       = 1'b1;
            next_busy      = 1'b0;
            next_cmdStatus = SMC_CMD_OK;
          end
          SMC_OP_STOP: begin
            if (state != SMC_IDLE) begin
              next_state = infAcc ? SMC_IDLE : SMC_DECEL; // [R9]
              next_speed = infAcc ? 32'h0 : speed;
              next_busy  = !infAcc;
            end
            next_moveMode  = 1'b0;
            next_hiZ       = 1'b0;
            next_cmdStatus = infAcc || state == SMC_IDLE ?
                             SMC_CMD_OK : SMC_CMD_BUSY;
          end
          SMC_OP_RUN, SMC_OP_MOVE: begin
            if (startOk && !(cmdCode == SMC_OP_MOVE && cmdSteps == 24'h0))
            begin
              next_hiZ       = 1'b0;
              next_busy      = 1'b1; // [R16]
              next_dirFwd    = cmdFwd;
              next_moveMode  = (cmdCode == SMC_OP_MOVE);
              next_remain    = cmdSteps;
              next_accSteps  = 24'h000000;
              next_stepAcc   = 32'h0;
              next_cmdStatus = SMC_CMD_BUSY; // [R20]
              next_state     = infAcc ? SMC_CONST : SMC_ACCEL; // [R8]
              next_speed     = infAcc ? maxSpd :
                               (speed > minSpd ? speed : minSpd);
            end else begin
              next_cmdStatus = SMC_CMD_ERR; // [R20]
            end
          end
          default: begin
            next_cmdStatus = SMC_CMD_ERR;
          end
        endcase
      end
    end
    if (hardStop && state != SMC_IDLE) begin // [R19]
      next_state     = SMC_IDLE;
      next_speed     = 32'h0;
      next_busy      = 1'b0;
      next_cmdStatus = SMC_CMD_ERR;
    end
    if (forceHiz) begin // [R3]
      next_state = SMC_IDLE;
      next_speed = 32'h0;
      next_hiZ   = 1'b1;
      next_busy  = 1'b0;
    end
    case (next_state)
      SMC_ACCEL: next_motStatus = SMC_MOT_ACC; // [R20]
      SMC_DECEL: next_motStatus = SMC_MOT_DEC;
      SMC_CONST: next_motStatus = SMC_MOT_CONST;
      default:   next_motStatus = SMC_MOT_STOP;
    endcase
    next_fullStep    = (next_speed > prm[10]); // [R13]
    next_lowSpeedOpt = (prm[9] == 32'h0); // [R12]
    next_infiniteAcc = infAcc; // [R8]
    next_stepRes     = (prm[5][7:4] > `SMC_RES_MAX) ? 3'(`SMC_RES_MAX) :
                       prm[5][6:4]; // [R5]
    case (next_state)
      SMC_ACCEL: next_phaseCur = prm[1][7:0]; // [R1]
      SMC_DECEL: next_phaseCur = prm[2][7:0];
      SMC_CONST: next_phaseCur = prm[4][7:0];
      default:   next_phaseCur = next_hiZ ? 8'h00 : prm[3][7:0];
    endcase
  end

  assign inBus.encMode = encMode;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state       <= SMC_IDLE;
      speed       <= 32'h0;
      stepAcc     <= 32'h0;
      remain      <= 24'h000000;
      accSteps    <= 24'h000000;
      moveMode    <= 1'b0;
      rampCnt     <= 18'h00000;
      usCnt       <= 8'h00;
      ready       <= 1'b0;
      hiZ         <= 1'b1; // [R15]
      busy        <= 1'b0;
      dirFwd      <= 1'b1;
      cmdStatus   <= SMC_CMD_OK;
      motStatus   <= SMC_MOT_STOP;
      stepPulse   <= 1'b0;
      fullStep    <= 1'b0;
      stepRes     <= 3'h0;
      phaseCur    <= 8'h00;
      phaseCurMa  <= 15'h0000;
      lowSpeedOpt <= 1'b0;
      infiniteAcc <= 1'b0;
      encMode     <= 1'b0;
      diLevel     <= 4'h0;
      encCount    <= 16'h0000;
    end else begin
      state       <= next_state;
      speed       <= next_speed;
      stepAcc     <= next_stepAcc;
      remain      <= next_remain;
      accSteps    <= next_accSteps;
      moveMode    <= next_moveMode;
      rampCnt     <= next_rampCnt;
      usCnt       <= next_usCnt;
      ready       <= 1'b1; // [R15]
      hiZ         <= next_hiZ;
      busy        <= next_busy;
      dirFwd      <= next_dirFwd;
      cmdStatus   <= next_cmdStatus;
      motStatus   <= next_motStatus;
      stepPulse   <= next_stepPulse;
      fullStep    <= next_fullStep;
      stepRes     <= next_stepRes;
      phaseCur    <= next_phaseCur;
      phaseCurMa  <= 15'(next_phaseCur) * `SMC_CUR_MA_LSB; // [R1]
      lowSpeedOpt <= next_lowSpeedOpt;
      infiniteAcc <= next_infiniteAcc;
      encMode     <= (prm[5][3:0] == `SMC_ENC_SEL); // [R6]
      diLevel     <= inBus.level;
      encCount    <= inBus.encCount;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  sequence s_driveWrite;
    cfgWrEn && !hiZ;
  endsequence
  sequence s_hardHit;
    hardStop && state != SMC_IDLE;
  endsequence

  chk_cfg_hiz_only: assert property (s_driveWrite |=> cfgReject &&
    prm[cfgIndex] == $past(prm[cfgIndex])) // [R2]
    else $error("config write taken while driving");
  chk_cur_forces_hiz: assert property (s_driveWrite ##0 curIdx |=> hiZ
    ##1 phaseCur == 8'h00 || !hiZ) // [R3]
    else $error("current write did not force high impedance");
  chk_cur_scale: assert property (phaseCurMa == 15'(phaseCur) *
    `SMC_CUR_MA_LSB) // [R1]
    else $error("current scale wrong");
  chk_res_range: assert property (stepRes <= 3'(`SMC_RES_MAX)) // [R5]
    else $error("step resolution out of range");
  chk_inf_no_ramp: assert property (infAcc |-> state != SMC_ACCEL &&
    state != SMC_DECEL) // [R8] [R9]
    else $error("ramp active in infinite acceleration");
  chk_speed_limit: assert property (speed <= prm[8] && prm[8] <=
    `SMC_MAX_MAX && prm[8] >= `SMC_MAX_MIN) // [R10] [R21]
    else $error("speed above limit");
  chk_low_speed: assert property ($changed(prm[9]) |=>
    lowSpeedOpt == (prm[9] == 32'h0)) // [R12]
    else $error("low speed optimisation mismatch");
  chk_full_step: assert property (fullStep |-> speed > 32'h0
    && speed > $past(prm[10])) // [R13]
    else $error("full step flag without speed");
  chk_hard_stop: assert property (s_hardHit |=> state == SMC_IDLE &&
    !busy ##1 motStatus == SMC_MOT_STOP || busy) // [R19]
    else $error("hard stop did not stop motor");
  chk_cmd_busy: assert property (cmdValid && cmdCode == SMC_OP_RUN &&
    startOk && !forceHiz |=> busy && cmdStatus == SMC_CMD_BUSY) // [R16]
    else $error("run command not executing");
endmodule : smc_top

// File: testbench.sv
// Self-checking bench for the stepper motion block
`timescale 1ns/1ps
`include "smc_cfg.svh"
module testbench;
  logic        clock, arst_n, cfgWrEn, cmdValid, cmdFwd, posTableMode;
  logic        ready, hiZ, busy, dirFwd, cfgReject, stepPulse, fullStep;
  logic        lowSpeedOpt, infiniteAcc, encMode;
  logic [1:0]  cmdStatus, motStatus, diReq, stopReq;
  logic [2:0]  stepRes, cmdCode;
  logic [3:0]  cfgIndex, diLevel, fieldIn;
  logic [7:0]  phaseCur, cur;
  logic [14:0] phaseCurMa;
  logic [15:0] encCount, steps, base;
  logic [23:0] cmdSteps;
  logic [31:0] cfgData;
  logic [31:0] seen [17];
  int          mismatches = 0, totalChecks = 0;
  typedef struct {int id; logic [31:0] exp;} smc_note_t;
  smc_note_t   notes[$];
  smc_note_t   cur_note;
  event        sampleNow;
  string nm[17] = '{"ready", "hiZ", "busy", "cmdStatus", "motStatus",
    "cfgReject", "stepRes", "encMode", "lowSpeedOpt", "infiniteAcc",
    "phaseCur", "phaseCurMa", "fullStep", "diLevel", "steps", "dirFwd",
    "encCount"};
  assign seen = '{32'(ready), 32'(hiZ), 32'(busy), 32'(cmdStatus),
    32'(motStatus), 32'(cfgReject), 32'(stepRes), 32'(encMode),
    32'(lowSpeedOpt), 32'(infiniteAcc), 32'(phaseCur), 32'(phaseCurMa),
    32'(fullStep), 32'(diLevel), 32'(steps), 32'(dirFwd),
    32'(encCount)};
  smc_top #(.RAMP_CYCLES(50)) smc_top_i (.clock, .arst_n, .cfgWrEn,
    .cfgIndex, .cfgData, .cmdValid, .cmdCode, .cmdFwd, .cmdSteps,
    .posTableMode, .fieldIn, .ready, .hiZ, .busy, .dirFwd, .cmdStatus,
    .motStatus, .cfgReject, .stepPulse, .fullStep, .stepRes, .phaseCur,
    .phaseCurMa, .lowSpeedOpt, .infiniteAcc, .encMode, .diLevel,
    .encCount);
  smc_field_model smc_field_model_i (.clock, .arst_n, .diReq, .stopReq,
    .stepPulse, .fieldIn, .steps);
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic check(logic [31:0] got, logic [31:0] exp, string what);
    totalChecks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check
  task automatic tick(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  task automatic want(int id, logic [31:0] exp);
    notes.push_back('{id, exp});
  endtask : want
  task automatic look;
    ->sampleNow;
    tick(1);
  endtask : look
  task automatic cfg(logic [3:0] idx, logic [31:0] val);
    cfgIndex = idx;
    cfgData = val;
    cfgWrEn = 1'b1;
    tick(1);
    cfgWrEn = 1'b0;
  endtask : cfg
  task automatic cmd(logic [2:0] code, logic [23:0] n);
    cmdCode = code;
    cmdSteps = n;
    cmdValid = 1'b1;
    tick(1);
    cmdValid = 1'b0;
  endtask : cmd
  task automatic conclude;
    $display("checks %0d mismatches %0d", totalChecks, mismatches);
    if (mismatches == 0 && totalChecks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude
  // ****************************************************************
  // Clock, monitor and watchdog
  // ****************************************************************
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial forever begin
    @(sampleNow);
    while (notes.size() > 0) begin
      cur_note = notes.pop_front();
      check(seen[cur_note.id], cur_note.exp, nm[cur_note.id]);
    end
  end
  initial begin
    #400000;
    mismatches++;
    conclude();
  end
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    arst_n = 1'b0; cfgWrEn = 1'b0; cfgIndex = 4'h0; cfgData = 32'h0;
    cmdValid = 1'b0; cmdCode = 3'h0; cmdFwd = 1'b1; cmdSteps = 24'h0;
    posTableMode = 1'b0; diReq = 2'h0; stopReq = 2'h0;
    void'($urandom(32'h919D));
    repeat (6) @(posedge clock);
    #1 arst_n = 1'b1;
    tick(1);
    want(0, 1); want(1, 1); want(2, 0); want(4, 0);
    want(3, 0); want(6, 4); want(8, 1); look();
    // Writes below up to the first run command happen with outputs in high impedance
    for (int m = 0; m < 6; m++) begin
      cfg(4'h5, 32'((m << 4) | (m == 1)));
      tick(1);
      want(6, (m > 4) ? 4 : m); want(7, m == 1); look();
    end
    diReq = 2'h3;
    tick(3);
    want(13, 4'h3); look();
    diReq = 2'h0;
    cfg(4'h5, 32'h41); tick(1); want(7, 1); look();
    for (int k = 0; k < 4; k++) begin
      diReq = 2'(8'h2D >> (2 * k));
      tick(1);
    end
    tick(3); want(16, 4); look();
    cfg(4'h9, 32'h64); tick(1); want(8, 0); look();
    cfg(4'h9, 32'h0); tick(1); want(8, 1); look();
    cfg(4'h6, 32'h5A_ED57); tick(1); want(9, 0); look();
    cfg(4'h6, 32'hFFFF_FFFF); tick(1); want(9, 1); look();
    cfg(4'h8, 32'hFFFF_FFFF); tick(1);
    cur = 8'($urandom_range(255, 1));
    cfg(4'h4, 32'(cur));
    cmd(3'h3, 24'h0);
    want(1, 0); want(2, 1); want(3, 2); want(4, 3);
    want(10, cur); want(11, cur * 78); look();
    tick(10); want(12, 1); look();
    cfg(4'h8, 32'h64); want(5, 1); want(1, 0); look();
    cfg(4'h1, 32'h20); want(1, 1); want(2, 0); look();
    cmd(3'h3, 24'h0);
    stopReq = 2'h1;
    tick(4);
    want(2, 0); want(3, 1); want(4, 0); want(1, 0); look();
    cmd(3'h3, 24'h0); want(3, 1); look();
    stopReq = 2'h0;
    tick(3);
    posTableMode = 1'b1;
    cmd(3'h3, 24'h0); want(3, 1); look();
    posTableMode = 1'b0;
    cmd(3'h4, 24'h0); want(3, 1); look();
    base = steps;
    cmdFwd = 1'($urandom_range(1, 0));
    cmd(3'h4, 24'h2);
    for (int i = 0; i < 40000 && busy !== 1'b0; i++) tick(1);
    tick(1);
    want(14, base + 2); want(3, 0); want(4, 0);
    want(1, 0); want(2, 0); want(15, cmdFwd); look();
    cmd(3'h3, 24'h0); want(2, 1); look();
    cmd(3'h2, 24'h0); want(2, 0); want(3, 0); want(4, 0);
    want(10, `SMC_RST_CUR); want(1, 0); look();
    cmd(3'h1, 24'h0); want(1, 1); look();
    #1;
    conclude();
  end
endmodule : testbench
